// ==== design/usfw_top.sv ====
// SOF frame capture and SOF/EOP timeout watchdog for two device ports, with an AHB-Lite register slave.
//
// Contract
// [RL1] Two independent frame number and count register pairs exist, one per port, at separate addresses.
// [RL2] The frame number register is read only and holds the last SOF frame number plus timeout bookkeeping.
// [RL3] In full-speed operation bits 10:0 capture each received SOF frame number; in low speed they hold.
// [RL4] A timeout leaves the frame field at the last frame number received.
// [RL5] Bit 15 of the frame number register reads 1 once a timeout interrupt has occurred, else 0.
// [RL6] Bits 14:12 count timeout interrupts by one from 0 up to 7.
// [RL7] The timeout counter clears to zero whenever an SOF or EOP is received on that port; the code clears it only while ien is set.
// [RL8] The timeout counter changes only while the port's timeout interrupt enable bit is set.
// [RL9] All frame number register bits reset to zero.
// [RL10] The count register takes the expected SOF/EOP interval and expiry before the next event raises a timeout.
// [RL11] The timeout enable sits in the port's interrupt enable register and the flag in its status register.
// [RL12] The interval counter decrements once per 12 MHz tick.
// [RL13] Software programs the count slightly above the interval, a little over 0x2EE0 for 1 ms.
// [RL14] Count register bits 15:14 are reserved and the rest reset to 0x2EE0.
// [RL15] The count field, bits 13:0, reads the current down counter and loads 0x2EE0 at reset.
// [RL16] Software writes zero to every reserved bit.
// [RL17] Each received SOF/EOP reloads the interval counter from the programmed count and restarts it.
`timescale 1ns/1ps
`default_nettype none

module usfw_port (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_frame,
  input  wire logic        eop_seen,
  input  wire logic        full_speed,
  input  wire logic        wr_count,
  input  wire logic        wr_ien,
  input  wire logic        wr_istat,
  input  wire logic [31:0] wdata,
  output logic      [15:0] frame_reg,
  output logic      [13:0] count_now,
  output logic             ien,
  output logic             istat
);
  logic [10:0] frame;
  logic [10:0] next_frame;
  logic [2:0]  tocnt;
  logic [2:0]  next_tocnt;
  logic [13:0] reload;
  logic [13:0] next_reload;
  logic [13:0] next_count_now;
  logic        next_ien;
  logic        next_istat;
  logic        frame_event;
  logic        timeout;

  assign frame_event = sof_valid | eop_seen;
  assign timeout     = tick & ~frame_event & (count_now == '0);

  // Only a full-speed SOF carries a frame number worth keeping.
  always_comb begin
    next_frame = frame;
    if (sof_valid && full_speed) begin
      next_frame = sof_frame; // [RL3] [RL4]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame <= 11'h000; // [RL9]
    end else begin
      frame <= next_frame;
    end
  end

  always_comb begin
    next_reload    = reload;
    next_count_now = count_now;
    if (wr_count) begin
      // A write also restarts the countdown so a new interval takes effect at once.
      next_reload    = wdata[usfw_pkg::COUNT_W-1:0]; // [RL10] [RL14]
      next_count_now = wdata[usfw_pkg::COUNT_W-1:0];
    end else if (frame_event) begin
      next_count_now = reload; // [RL17]
    end else if (tick) begin
      if (count_now == '0) begin
        // Reloading after expiry lets a missing host raise one timeout per interval.
        next_count_now = reload;
      end else begin
        next_count_now = count_now - 14'h0001; // [RL12]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reload    <= usfw_pkg::COUNT_RESET; // [RL15]
      count_now <= usfw_pkg::COUNT_RESET;
    end else begin
      reload    <= next_reload;
      count_now <= next_count_now;
    end
  end

  always_comb begin
    next_ien   = ien;
    next_istat = istat;
    if (wr_ien) begin
      next_ien = wdata[usfw_pkg::TO_IRQ_BIT];
    end
    if (wr_istat && wdata[usfw_pkg::TO_IRQ_BIT]) begin
      next_istat = 1'b0;
    end
    // The set comes after the clear so that a timeout in the clearing cycle is not lost.
    if (timeout) begin
      next_istat = 1'b1; // [RL10] [RL11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ien   <= 1'b0;
      istat <= 1'b0;
    end else begin
      ien   <= next_ien;
      istat <= next_istat;
    end
  end

  always_comb begin
    next_tocnt = tocnt;
    if (ien) begin // [RL8]
      if (frame_event) begin
        next_tocnt = 3'h0; // [RL7]
      end else if (timeout && tocnt != usfw_pkg::TOCNT_MAX) begin
        // Holding at the top keeps a long outage from wrapping back to a small count.
        next_tocnt = tocnt + 3'h1; // [RL6]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tocnt <= 3'h0; // [RL9]
    end else begin
      tocnt <= next_tocnt;
    end
  end

  // Bit 11 is reserved and reads zero.
  assign frame_reg = {istat, tocnt, 1'b0, frame}; // [RL2] [RL5]
endmodule : usfw_port

// Matches one register index while a bus write is in its data phase.
module usfw_reg_hit #(
  parameter logic [15:0] IDX = 16'h0000
) (
  input  wire logic        en,
  input  wire logic [15:0] idx,
  output logic             hit
);
  assign hit = en && (idx == IDX);
endmodule : usfw_reg_hit

module usfw_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        p1_sof_valid,
  input  wire logic [10:0] p1_sof_frame,
  input  wire logic        p1_eop_seen,
  input  wire logic        p1_full_speed,
  input  wire logic        p2_sof_valid,
  input  wire logic [10:0] p2_sof_frame,
  input  wire logic        p2_eop_seen,
  input  wire logic        p2_full_speed,
  output logic             irq
);
  logic [usfw_pkg::ACC_W-1:0] acc;
  logic [usfw_pkg::ACC_W-1:0] next_acc;
  logic                       tick;
  logic                       next_tick;
  logic                       wr_pend;
  logic                       next_wr_pend;
  logic [15:0]                wr_idx;
  logic [15:0]                next_wr_idx;
  logic [31:0]                next_hrdata;
  logic [15:0]                rd_idx;
  logic                       wr_go;
  logic [15:0]                p1_frame_reg;
  logic [15:0]                p2_frame_reg;
  logic [13:0]                p1_count;
  logic [13:0]                p2_count;
  logic                       p1_ien;
  logic                       p2_ien;
  logic                       p1_istat;
  logic                       p2_istat;
  logic                       wr_p1_count;
  logic                       wr_p1_ien;
  logic                       wr_p1_istat;
  logic                       wr_p2_count;
  logic                       wr_p2_ien;
  logic                       wr_p2_istat;
  logic [31:0]                rd_word;

  // Fractional divider: adds 12 per clock modulo 125, giving exactly 12 ticks per microsecond on average.
  always_comb begin
    next_tick = 1'b0;
    next_acc  = acc + usfw_pkg::ACC_W'(usfw_pkg::TICK_MHZ);
    if (next_acc >= usfw_pkg::ACC_W'(usfw_pkg::SYS_CLK_MHZ)) begin
      next_acc  = next_acc - usfw_pkg::ACC_W'(usfw_pkg::SYS_CLK_MHZ);
      next_tick = 1'b1; // [RL12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc  <= '0;
      tick <= 1'b0;
    end else begin
      acc  <= next_acc;
      tick <= next_tick;
    end
  end

  assign rd_idx    = haddr[usfw_pkg::IDX_LSB +: usfw_pkg::IDX_W];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_go     = wr_pend;

  // A write's address is held into its data phase, where the write data finally stands.
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_idx  = wr_idx;
    if (hsel && htrans[1] && hready) begin
      next_wr_pend = hwrite;
      next_wr_idx  = rd_idx;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_idx  <= 16'h0000;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx  <= next_wr_idx;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx) // [RL1]
      usfw_pkg::P1_FRAME_IDX: rd_word = {16'h0000, p1_frame_reg}; // [RL2]
      usfw_pkg::P1_COUNT_IDX: rd_word = {18'h00000, p1_count}; // [RL15]
      usfw_pkg::P2_FRAME_IDX: rd_word = {16'h0000, p2_frame_reg};
      usfw_pkg::P2_COUNT_IDX: rd_word = {18'h00000, p2_count};
      usfw_pkg::P1_IEN_IDX:   rd_word = {31'h00000000, p1_ien};
      usfw_pkg::P1_ISTAT_IDX: rd_word = {31'h00000000, p1_istat};
      usfw_pkg::P2_IEN_IDX:   rd_word = {31'h00000000, p2_ien};
      usfw_pkg::P2_ISTAT_IDX: rd_word = {31'h00000000, p2_istat};
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is sampled at the address phase; a read right after a write sees the pre-write value.
  always_comb begin
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready) begin
      next_hrdata = hwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // One decoder per writable register keeps each strobe a single compare.
  usfw_reg_hit #(
    .IDX (usfw_pkg::P1_COUNT_IDX)
  ) u_hit_p1_count (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p1_count)
  );

  usfw_reg_hit #(
    .IDX (usfw_pkg::P1_IEN_IDX)
  ) u_hit_p1_ien (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p1_ien)
  );

  usfw_reg_hit #(
    .IDX (usfw_pkg::P1_ISTAT_IDX)
  ) u_hit_p1_istat (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p1_istat)
  );

  usfw_reg_hit #(
    .IDX (usfw_pkg::P2_COUNT_IDX)
  ) u_hit_p2_count (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p2_count)
  );

  usfw_reg_hit #(
    .IDX (usfw_pkg::P2_IEN_IDX)
  ) u_hit_p2_ien (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p2_ien)
  );

  usfw_reg_hit #(
    .IDX (usfw_pkg::P2_ISTAT_IDX)
  ) u_hit_p2_istat (
    .en  (wr_go),
    .idx (wr_idx),
    .hit (wr_p2_istat)
  );

  usfw_port u_port1 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .tick       (tick),
    .sof_valid  (p1_sof_valid),
    .sof_frame  (p1_sof_frame),
    .eop_seen   (p1_eop_seen),
    .full_speed (p1_full_speed),
    .wr_count   (wr_p1_count),
    .wr_ien     (wr_p1_ien),
    .wr_istat   (wr_p1_istat),
    .wdata      (hwdata),
    .frame_reg  (p1_frame_reg),
    .count_now  (p1_count),
    .ien        (p1_ien),
    .istat      (p1_istat)
  );

  usfw_port u_port2 (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .tick       (tick),
    .sof_valid  (p2_sof_valid),
    .sof_frame  (p2_sof_frame),
    .eop_seen   (p2_eop_seen),
    .full_speed (p2_full_speed),
    .wr_count   (wr_p2_count),
    .wr_ien     (wr_p2_ien),
    .wr_istat   (wr_p2_istat),
    .wdata      (hwdata),
    .frame_reg  (p2_frame_reg),
    .count_now  (p2_count),
    .ien        (p2_ien),
    .istat      (p2_istat)
  );

  assign irq = (p1_istat & p1_ien) | (p2_istat & p2_ien); // [RL11]
endmodule : usfw_top

`default_nettype wire

// ==== design/usfw_pkg.sv ====
// Package with register map, field layout, reset values and timing constants of the SOF frame watchdog.
package usfw_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] P1_FRAME_IDX   = 16'hc092;
  localparam logic [15:0] P1_COUNT_IDX   = 16'hc094;
  localparam logic [15:0] P2_FRAME_IDX   = 16'hc0b2;
  localparam logic [15:0] P2_COUNT_IDX   = 16'hc0b4;
  localparam logic [15:0] P1_IEN_IDX     = 16'hc08c;
  localparam logic [15:0] P1_ISTAT_IDX   = 16'hc090;
  localparam logic [15:0] P2_IEN_IDX     = 16'hc0ac;
  localparam logic [15:0] P2_ISTAT_IDX   = 16'hc0b0;
  localparam int          IDX_LSB        = 2;
  localparam int          IDX_W          = 16;

  // Frame number register layout.
  localparam int          FRAME_W        = 11;
  localparam int          TOCNT_LSB      = 12;
  localparam int          TOCNT_W        = 3;
  localparam int          TOFLAG_BIT     = 15;
  localparam logic [2:0]  TOCNT_MAX      = 3'h7;

  // Count register layout and reset value.
  localparam int          COUNT_W        = 14;
  localparam logic [13:0] COUNT_RESET    = 14'h2ee0;

  // Interrupt enable and status bit of the timeout event.
  localparam int          TO_IRQ_BIT     = 0;

  // Time base: 12 MHz ticks derived from the 125 MHz clock by a fractional accumulator.
  localparam int          SYS_CLK_MHZ    = 125;
  localparam int          TICK_MHZ       = 12;
  localparam int          ACC_W          = 8;
endpackage : usfw_pkg

// ==== test/usfw_host.sv ====
// Behavioural USB host that issues SOF and EOP events on one device port.
`timescale 1ns/1ps
`default_nettype none
module usfw_host (
  input  wire logic        sys_clk,
  input  wire logic        send_sof,
  input  wire logic        send_eop,
  input  wire logic [10:0] frame_in,
  output logic             sof_valid,
  output logic      [10:0] sof_frame,
  output logic             eop_seen
);
  initial begin
    sof_valid = 1'b0;
    eop_seen  = 1'b0;
    sof_frame = 11'h0;
  end
  // Outside an SOF the frame lines toggle, so a late capture reads garbage.
  always @(posedge sys_clk) begin
    sof_valid <= send_sof;
    eop_seen  <= send_eop;
    sof_frame <= send_sof ? frame_in : ~sof_frame;
  end
endmodule : usfw_host
`default_nettype wire

// ==== test/usfw_top_properties.sv ====
// Concurrent checks on the register bus and interrupt pin of the watchdog.
`timescale 1ns/1ps
`default_nettype none
module usfw_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq
);
  logic        ap;
  logic        rd;
  logic        mapped;
  logic [15:0] idx;
  logic        wr_dp;
  logic        next_wr_dp;
  assign ap     = hsel & htrans[1] & hready;
  assign rd     = ap & ~hwrite;
  assign idx    = haddr[17:2];
  assign mapped = (haddr[31:18] != 14'h0) || (idx inside {usfw_pkg::P1_FRAME_IDX, usfw_pkg::P1_COUNT_IDX,
    usfw_pkg::P2_FRAME_IDX, usfw_pkg::P2_COUNT_IDX, usfw_pkg::P1_IEN_IDX, usfw_pkg::P1_ISTAT_IDX,
    usfw_pkg::P2_IEN_IDX, usfw_pkg::P2_ISTAT_IDX});
  always_comb next_wr_dp = rst ? 1'b0 : ap & hwrite;
  always_ff @(posedge sys_clk) wr_dp <= next_wr_dp;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  resp_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  reset_quiet_a: assert property ($past(rst) |-> hrdata == 32'h0 && !irq) else $error("not quiet");
  unmapped_zero_a: assert property (rd && !mapped |=> hrdata == 32'h0) else $error("unmapped data");
  upper_zero_a: assert property (rd |=> hrdata[31:16] == 16'h0) else $error("upper half set");
  frame_resv_a: assert property (rd && (idx == usfw_pkg::P1_FRAME_IDX || idx == usfw_pkg::P2_FRAME_IDX)
    |=> !hrdata[11]) else $error("frame reserved bit set");
  count_resv_a: assert property (rd && (idx == usfw_pkg::P1_COUNT_IDX || idx == usfw_pkg::P2_COUNT_IDX)
    |=> hrdata[15:14] == 2'h0) else $error("count reserved bits set");
  rdata_hold_a: assert property (!ap |=> $stable(hrdata)) else $error("read data moved");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_dp)) else $error("irq fell without write");
  cover property ($rose(irq));
  cover property (rd && !mapped);
  cover property (ap && hwrite ##2 $fell(irq));
endmodule : usfw_chk
bind usfw_top usfw_chk u_chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

// ==== test/tb.sv ====
// Register-level testbench of the SOF frame watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  snd_sof = 2'h0;
  logic [1:0]  snd_eop = 2'h0;
  logic [10:0] f_in    = 11'h0;
  logic [1:0]  fs      = 2'h1;
  logic [1:0]  sv;
  logic [1:0]  ev;
  logic [10:0] sf1;
  logic [10:0] sf2;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hreadyout;
  logic        irq;
  int          failures = 0;
  int          compares = 0;
  int          cyc      = 0;
  int          n;
  always #4 sys_clk = ~sys_clk;
  usfw_host u_h1 (.sys_clk(sys_clk), .send_sof(snd_sof[0]), .send_eop(snd_eop[0]), .frame_in(f_in),
    .sof_valid(sv[0]), .sof_frame(sf1), .eop_seen(ev[0]));
  usfw_host u_h2 (.sys_clk(sys_clk), .send_sof(snd_sof[1]), .send_eop(snd_eop[1]), .frame_in(f_in),
    .sof_valid(sv[1]), .sof_frame(sf2), .eop_seen(ev[1]));
  // Port 2 starts in low speed so that its frame field must not capture until it is switched over.
  usfw_top u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .p1_sof_valid(sv[0]), .p1_sof_frame(sf1), .p1_eop_seen(ev[0]), .p1_full_speed(fs[0]),
    .p2_sof_valid(sv[1]), .p2_sof_frame(sf2), .p2_eop_seen(ev[1]), .p2_full_speed(fs[1]), .irq(irq));
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {14'h0, idx, 2'h0};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input string what);
    bus(1'b0, idx, 32'h0);
    chk(q === exp, what);
  endtask : rd
  task automatic evt(input int p, input logic eop, input logic [10:0] f);
    if (eop)
      snd_eop[p] <= 1'b1;
    else
      snd_sof[p] <= 1'b1;
    f_in <= f;
    @(posedge sys_clk);
    snd_sof <= 2'h0;
    snd_eop <= 2'h0;
    repeat (2) @(posedge sys_clk);
  endtask : evt
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h0, "p1 frame reset");
    rd(usfw_pkg::P2_FRAME_IDX, 32'h0, "p2 frame reset");
    bus(1'b0, usfw_pkg::P1_COUNT_IDX, 32'h0);
    chk(q[31:14] === 18'h0 && q[13:0] >= 14'h2ed8, "count reset");
    rd(16'hc096, 32'h0, "unmapped read");
    bus(1'b1, usfw_pkg::P1_FRAME_IDX, 32'hffff);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h0, "frame write ignored");
    $display("test reset done");
    evt(0, 1'b0, 11'h5a5);
    evt(1, 1'b0, 11'h123);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h5a5, "full speed capture");
    rd(usfw_pkg::P2_FRAME_IDX, 32'h0, "low speed no capture");
    $display("test capture done");
    bus(1'b1, usfw_pkg::P1_IEN_IDX, 32'h1);
    bus(1'b1, usfw_pkg::P1_COUNT_IDX, 32'h5);
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge sys_clk);
    chk(n >= 48 && n <= 80, "timeout delay");
    rd(usfw_pkg::P1_FRAME_IDX, 32'h95a5, "first timeout");
    repeat (500) @(posedge sys_clk);
    rd(usfw_pkg::P1_FRAME_IDX, 32'hf5a5, "count saturates");
    evt(0, 1'b1, 11'h0);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h85a5, "eop clears count");
    bus(1'b1, usfw_pkg::P1_ISTAT_IDX, 32'h1);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h5a5, "flag cleared");
    chk(irq === 1'b0, "irq cleared");
    bus(1'b1, usfw_pkg::P1_IEN_IDX, 32'h0);
    repeat (150) @(posedge sys_clk);
    rd(usfw_pkg::P1_FRAME_IDX, 32'h85a5, "count frozen");
    chk(irq === 1'b0, "irq masked");
    $display("test timeout done");
    bus(1'b1, usfw_pkg::P2_COUNT_IDX, 32'h100);
    repeat (100) @(posedge sys_clk);
    bus(1'b0, usfw_pkg::P2_COUNT_IDX, 32'h0);
    chk(q[13:0] >= 14'hf5 && q[13:0] <= 14'hf8, "down count rate");
    evt(1, 1'b1, 11'h0);
    bus(1'b0, usfw_pkg::P2_COUNT_IDX, 32'h0);
    chk(q[13:0] >= 14'hff && q[13:0] <= 14'h100, "reload on eop");
    $display("test reload done");
    fs <= 2'h3;
    bus(1'b1, usfw_pkg::P2_IEN_IDX, 32'h1);
    bus(1'b1, usfw_pkg::P2_COUNT_IDX, 32'h10);
    repeat (3) begin
      repeat (120) @(posedge sys_clk);
      evt(1, 1'b0, 11'h3c3);
    end
    rd(usfw_pkg::P2_ISTAT_IDX, 32'h0, "no timeout inside interval");
    rd(usfw_pkg::P2_FRAME_IDX, 32'h3c3, "p2 full speed capture");
    repeat (200) @(posedge sys_clk);
    rd(usfw_pkg::P2_ISTAT_IDX, 32'h1, "p2 timeout flag");
    chk(irq === 1'b1, "p2 irq");
    rd(usfw_pkg::P2_FRAME_IDX, 32'h93c3, "p2 timeout count");
    rd(usfw_pkg::P1_FRAME_IDX, 32'h85a5, "p1 untouched");
    $display("test port two done");
    conclude();
  end
endmodule : tb
`default_nettype wire
